// ==== hdl/gex_params.svh ====
// Purpose: constants for the I2C GPIO expander
// Assumes: sys_clk at 100 MHz
// Notes: register pointers, reset values and bus address fields
`ifndef GEX_PARAMS_SVH
`define GEX_PARAMS_SVH
`define GEX_PTR_IN0 3'h0
`define GEX_PTR_IN1 3'h1
`define GEX_PTR_OUT0 3'h2
`define GEX_PTR_OUT1 3'h3
`define GEX_PTR_INV0 3'h4
`define GEX_PTR_INV1 3'h5
`define GEX_PTR_DIR0 3'h6
`define GEX_PTR_DIR1 3'h7
`define GEX_RST_OUT 8'hFF
`define GEX_RST_INV 8'h00
`define GEX_RST_DIR 8'hFF
`define GEX_ADDR_HI 5'h14
`define GEX_BIT_LAST 3'h7
`define GEX_PTR_W 3
`define GEX_SETTLE 2'h2
`endif

// ==== hdl/gex_pkg.sv ====
// Purpose: types for the I2C GPIO expander
// Assumes: nothing
// Notes: serial engine states
package gex_pkg;
  typedef enum logic [2:0] {
    GEX_IDLE, GEX_ADDR, GEX_ADDR_ACK, GEX_WR, GEX_WR_ACK, GEX_RD, GEX_RD_ACK
  } gex_state_t;
endpackage

// ==== hdl/gex_sync.sv ====
// Purpose: two-flop synchroniser for an asynchronous input vector
// Assumes: destination clock is sys_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module gex_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ==== hdl/gex_top.sv ====
// Purpose: sixteen-bit GPIO expander, target on a two-wire serial bus
// Assumes: scl and sda sampled by sys_clk, much faster than the link
// Notes: registers and serial engine reset by rst_n, the power-on and pin reset
// Operation
// - Power-up loads every register default and idles the serial engine.
// - The active-low reset pin performs the same initialisation as power-up.
// - The two low address bits come from two strap pins.
// - Address LSB one means read from the device, zero means write.
// - The first byte after a write address is the command byte setting the pointer.
// - Pointers 0-7 select input, output, inversion and direction pairs.
// - Output resets to FF, inversion to 00, direction to FF so all pins are inputs.
// - Input registers show sampled pin levels whatever the pin direction.
// - Writes to the input registers are discarded.
// - An output bit drives only a pin set as output.
// - Reading an output register returns the stored flip-flop value.
// - An active-low open-drain interrupt line reports input activity.
// - An inversion bit of one inverts the read input bit, zero passes it.
// - Direction one makes a high-impedance input, zero drives the output value.
// - Interrupt on input pin change, cleared by return or by reading that port.
// - After each data byte the pointer toggles within its pair, without limit.
`timescale 1ns/1ps
`include "gex_params.svh"
module gex_top (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic scl_in, // Serial clock pin
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive value
  output logic sda_oe, // Serial data pull-low enable
  input wire logic addr_strap_lo, // Address strap bit 0
  input wire logic addr_strap_hi, // Address strap bit 1
  input wire logic [15:0] gpio_in, // Pin levels, port1 high byte
  output logic [15:0] gpio_out, // Pin drive values
  output logic [15:0] gpio_oe, // Pin drive enables
  output logic int_n_out, // Interrupt open-drain drive value
  output logic int_n_oe // Interrupt pull-low enable
);
  import gex_pkg::*;

  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic [1:0] strap_s;
  logic [15:0] pins_s;
  gex_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [`GEX_PTR_W-1:0] ptr_reg;
  logic cmd_seen_reg;
  logic [7:0] drive_value_port0_reg, drive_value_port1_reg;
  logic [7:0] invert_port0_reg, invert_port1_reg;
  logic [7:0] direction_port0_reg, direction_port1_reg;
  logic [15:0] snap_reg;
  logic [1:0] strap_reg;
  logic strap_taken_reg;
  logic [1:0] settle_reg;
  logic [7:0] rd_byte;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic addr_match;
  logic [7:0] shift_next;
  logic byte_end;
  logic [1:0] read_clr;

  // Level inputs pass two flops before use
  gex_sync #(.W(2), .INIT(2'h3)) u_sync_bus (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );
  gex_sync #(.W(18), .INIT(18'h00000)) u_sync_pins (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({addr_strap_hi, addr_strap_lo, gpio_in}),
    .q({strap_s, pins_s})
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign shift_next = {shift_reg[6:0], sda_s};
  assign byte_end = (bit_reg == `GEX_BIT_LAST);

  // Straps and snapshot wait until the pin synchroniser holds real levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= 2'h0;
      settle_reg <= 2'h0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_reg <= strap_s;
      settle_reg <= settle_reg + 2'h1;
      strap_taken_reg <= (settle_reg == `GEX_SETTLE);
    end
  end

  assign addr_match = (shift_next[7:1] == {`GEX_ADDR_HI, strap_reg});

  // Read data: input through inversion, others straight from flops
  always_comb begin
    case (ptr_reg)
      `GEX_PTR_IN0: rd_byte = pins_s[7:0] ^ invert_port0_reg;
      `GEX_PTR_IN1: rd_byte = pins_s[15:8] ^ invert_port1_reg;
      `GEX_PTR_OUT0: rd_byte = drive_value_port0_reg;
      `GEX_PTR_OUT1: rd_byte = drive_value_port1_reg;
      `GEX_PTR_INV0: rd_byte = invert_port0_reg;
      `GEX_PTR_INV1: rd_byte = invert_port1_reg;
      `GEX_PTR_DIR0: rd_byte = direction_port0_reg;
      default: rd_byte = direction_port1_reg;
    endcase
  end

  // Serial engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= GEX_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      cmd_seen_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state_reg <= GEX_ADDR;
      bit_reg <= 3'h0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= GEX_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        GEX_IDLE: begin
          sda_oe <= 1'b0;
        end
        GEX_ADDR: begin
          if (scl_rise) begin
            shift_reg <= shift_next;
            bit_reg <= bit_reg + 3'h1;
            if (byte_end) begin
              if (addr_match) begin
                state_reg <= GEX_ADDR_ACK;
              end else begin
                state_reg <= GEX_IDLE;
              end
            end
          end
        end
        GEX_ADDR_ACK: begin
          if (scl_fall) begin
            if (!sda_oe) begin
              sda_oe <= 1'b1;
            end else if (shift_reg[0]) begin
              state_reg <= GEX_RD;
              shift_reg <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              state_reg <= GEX_WR;
              cmd_seen_reg <= 1'b0;
              sda_oe <= 1'b0;
            end
          end
        end
        GEX_WR: begin
          if (scl_rise) begin
            shift_reg <= shift_next;
            bit_reg <= bit_reg + 3'h1;
            if (byte_end) begin
              state_reg <= GEX_WR_ACK;
            end
          end
        end
        GEX_WR_ACK: begin
          if (scl_fall) begin
            if (!sda_oe) begin
              sda_oe <= 1'b1;
              cmd_seen_reg <= 1'b1;
            end else begin
              state_reg <= GEX_WR;
              sda_oe <= 1'b0;
            end
          end
        end
        GEX_RD: begin
          if (scl_fall) begin
            bit_reg <= bit_reg + 3'h1;
            if (byte_end) begin
              state_reg <= GEX_RD_ACK;
              sda_oe <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe <= ~shift_reg[6];
            end
          end
        end
        GEX_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_reg <= GEX_IDLE; // Master NACK ends the read
            end
          end else if (scl_fall) begin
            shift_reg <= rd_byte;
            sda_oe <= ~rd_byte[7];
            state_reg <= GEX_RD;
          end
        end
        default: begin
          state_reg <= GEX_IDLE;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;

  // Pointer load on command byte, toggle within pair after each data byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= `GEX_PTR_IN0;
    end else if (state_reg == GEX_WR && scl_rise && byte_end && !cmd_seen_reg) begin
      ptr_reg <= shift_next[`GEX_PTR_W-1:0];
    end else if (state_reg == GEX_WR && scl_rise && byte_end) begin
      ptr_reg <= ptr_reg ^ `GEX_PTR_W'(1);
    end else if (state_reg == GEX_RD && scl_fall && byte_end) begin
      ptr_reg <= ptr_reg ^ `GEX_PTR_W'(1);
    end
  end

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_value_port0_reg <= `GEX_RST_OUT;
      drive_value_port1_reg <= `GEX_RST_OUT;
      invert_port0_reg <= `GEX_RST_INV;
      invert_port1_reg <= `GEX_RST_INV;
      direction_port0_reg <= `GEX_RST_DIR;
      direction_port1_reg <= `GEX_RST_DIR;
    end else if (state_reg == GEX_WR && scl_rise && byte_end && cmd_seen_reg) begin
      case (ptr_reg)
        `GEX_PTR_OUT0: drive_value_port0_reg <= shift_next;
        `GEX_PTR_OUT1: drive_value_port1_reg <= shift_next;
        `GEX_PTR_INV0: invert_port0_reg <= shift_next;
        `GEX_PTR_INV1: invert_port1_reg <= shift_next;
        `GEX_PTR_DIR0: direction_port0_reg <= shift_next;
        `GEX_PTR_DIR1: direction_port1_reg <= shift_next;
        default: ;
      endcase
    end
  end

  // Drivers on pins set as outputs only
  assign gpio_out = {drive_value_port1_reg, drive_value_port0_reg};
  assign gpio_oe = ~{direction_port1_reg, direction_port0_reg};

  // Input port read loads the snapshot for that port
  assign read_clr[0] = (state_reg == GEX_RD) && scl_fall && byte_end && (ptr_reg == `GEX_PTR_IN0);
  assign read_clr[1] = (state_reg == GEX_RD) && scl_fall && byte_end && (ptr_reg == `GEX_PTR_IN1);

  // Snapshot per port, compared with live levels; input pins only
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          snap_reg[p*8 +: 8] <= 8'h00;
        end else if (!strap_taken_reg || read_clr[p]) begin
          snap_reg[p*8 +: 8] <= pins_s[p*8 +: 8];
        end
      end
    end
  endgenerate

  // Changes on output pins are masked; returning clears without a read
  // Held quiet while the snapshot is still filling after reset
  assign int_n_oe = strap_taken_reg & (|((snap_reg ^ pins_s) & ~gpio_oe));
  assign int_n_out = 1'b0;
endmodule

// ==== sim/gex_bus_master.sv ====
// Purpose: serial bus master model
// Assumes: 180 ns bus clock, pulled-up lines
// Notes: no clock stretching; clock stands high between frames
`timescale 1ns/1ps
module gex_bus_master (
  input wire logic sys_clk, // Clock
  output logic scl, // Bus clock
  output logic sda_low, // Pull data low
  input wire logic sda // Resolved data
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // Data moves only while the clock is low
  task automatic xfer(input logic b, output logic r);
    repeat (2) @(negedge sys_clk);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(b[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask
  // Released line on the last byte is the final no-acknowledge
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, b[i]);
    xfer(last, r);
  endtask
endmodule

// ==== sim/gex_top_sva.sv ====
// Purpose: port checks for the expander
// Assumes: one sys_clk domain, rst_n async
// Notes: quiet counters saturate at 15
`timescale 1ns/1ps
module gex_top_sva (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic scl_in, // Bus clock
  input wire logic sda_in, // Bus data
  input wire logic sda_out, // Data drive
  input wire logic sda_oe, // Data pull-low
  input wire logic addr_strap_lo, // Strap 0
  input wire logic addr_strap_hi, // Strap 1
  input wire logic [15:0] gpio_in, // Pins
  input wire logic [15:0] gpio_out, // Drive
  input wire logic [15:0] gpio_oe, // Enable
  input wire logic int_n_out, // Int drive
  input wire logic int_n_oe // Int pull-low
);
  logic [3:0] pin_q;
  logic [3:0] scl_q;
  // Cycles since the pins last moved
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pin_q <= 4'h0;
    else if ($changed(gpio_in)) pin_q <= 4'h0;
    else if (pin_q != 4'hF) pin_q <= pin_q + 4'h1;
  end
  // Cycles since the bus clock last moved
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) scl_q <= 4'h0;
    else if ($changed(scl_in)) scl_q <= 4'h0;
    else if (scl_q != 4'hF) scl_q <= scl_q + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int_drv_a: assert property (int_n_out == 1'b0) else $error("int drive high");
  sda_drv_a: assert property (sda_out == 1'b0) else $error("sda drive high");
  rst_init_a: assert property ($rose(rst_n) |->
    gpio_oe == 16'h0000 && gpio_out == 16'hFFFF && !sda_oe) else $error("bad reset state");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved");
  idle_rel_a: assert property (scl_in && scl_q == 4'hF |-> !sda_oe)
    else $error("sda held while idle");
  reg_hold_a: assert property ($changed(gpio_out) || $changed(gpio_oe) |-> scl_q < 4'h8)
    else $error("pins moved without bus");
  int_cause_a: assert property ($rose(int_n_oe) |-> pin_q < 4'h6)
    else $error("int without pin change");
  int_set_a: assert property ($changed(gpio_in & ~gpio_oe) && $stable(gpio_oe) &&
    !int_n_oe |-> ##[1:6] int_n_oe) else $error("int missed");
  int_clr_a: assert property ($fell(int_n_oe) |-> pin_q < 4'h6 || scl_q < 4'h8)
    else $error("int cleared alone");
endmodule
bind gex_top gex_top_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_lo(addr_strap_lo),
  .addr_strap_hi(addr_strap_hi), .gpio_in(gpio_in), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the expander
// Assumes: 100 MHz sys_clk, 180 ns bus clock
// Notes: straps 01, moved to 10 across a mid-run reset
`timescale 1ns/1ps
`include "gex_params.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] gpio_in = 16'hA55A;
  logic [1:0] strap = 2'b01;
  logic scl;
  logic sda_low;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic int_n_out;
  logic int_n_oe;
  logic [15:0] gpio_out;
  logic [15:0] gpio_oe;
  logic [15:0] q;
  logic ack;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [6:0] ADDR = {`GEX_ADDR_HI, 2'b01};
  always #5 sys_clk = ~sys_clk;
  assign sda = ~(sda_oe | sda_low);
  gex_bus_master bus (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  gex_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_lo(strap[0]), .addr_strap_hi(strap[1]),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .int_n_out(int_n_out),
    .int_n_oe(int_n_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
    logic k;
    bus.start();
    bus.wr_byte({a, 1'b0}, ack);
    bus.wr_byte(p, k);
    bus.wr_byte(d[7:0], k);
    bus.wr_byte(d[15:8], k);
    bus.stop();
  endtask
  // Low byte from p, high byte from its partner
  task automatic rreg(input logic [7:0] p);
    logic k;
    bus.start();
    bus.wr_byte({ADDR, 1'b0}, k);
    bus.wr_byte(p, k);
    bus.start();
    bus.wr_byte({ADDR, 1'b1}, k);
    chk({15'h0, k}, 16'h0001);
    bus.rd_byte(1'b0, q[7:0]);
    bus.rd_byte(1'b1, q[15:8]);
    bus.stop();
  endtask
  task automatic t_reset();
    chk(gpio_oe, 16'h0000);
    chk(gpio_out, 16'hFFFF);
    chk({15'h0, int_n_oe}, 16'h0000);
    bus.start();
    bus.wr_byte({ADDR, 1'b0}, ack);
    bus.wr_byte(8'h04, ack);
    bus.start();
    bus.wr_byte({ADDR, 1'b1}, ack);
    bus.rd_byte(1'b0, q[7:0]);
    bus.rd_byte(1'b1, q[15:8]);
    bus.stop();
    chk(q, 16'h0000);
    $display("done reset");
  endtask
  task automatic t_input();
    bus.start();
    bus.wr_byte({ADDR, 1'b0}, ack);
    bus.wr_byte(8'h01, ack);
    bus.start();
    bus.wr_byte({ADDR, 1'b1}, ack);
    bus.rd_byte(1'b0, q[7:0]);
    bus.rd_byte(1'b0, q[15:8]);
    bus.rd_byte(1'b1, q[7:0]);
    bus.stop();
    chk(q, 16'h5AA5);
    wreg(ADDR, 8'h00, 16'h0000);
    wreg(ADDR, 8'h04, 16'hF00F);
    rreg(8'h00);
    chk(q, 16'h5555);
    wreg(ADDR, 8'h04, 16'h0000);
    $display("done input");
  endtask
  task automatic t_output();
    wreg(ADDR, 8'h06, 16'hFF00);
    wreg(ADDR, 8'h02, 16'h0F3C);
    chk(gpio_oe, 16'h00FF);
    chk(gpio_out, 16'h0F3C);
    bus.start();
    bus.wr_byte({ADDR, 1'b0}, ack);
    bus.wr_byte(8'h02, ack);
    bus.start();
    bus.wr_byte({ADDR, 1'b1}, ack);
    bus.rd_byte(1'b0, q[7:0]);
    bus.rd_byte(1'b1, q[15:8]);
    bus.stop();
    chk(q, 16'h0F3C);
    wreg(ADDR ^ 7'h01, 8'h02, 16'h0000);
    chk({15'h0, ack}, 16'h0000);
    chk(gpio_out, 16'h0F3C);
    $display("done output");
  endtask
  task automatic t_irq();
    @(negedge sys_clk) gpio_in = 16'hA55B;
    repeat (10) @(negedge sys_clk);
    chk({15'h0, int_n_oe}, 16'h0000);
    gpio_in = 16'hA45B;
    repeat (10) @(negedge sys_clk);
    chk({15'h0, int_n_oe}, 16'h0001);
    gpio_in = 16'hA55B;
    repeat (10) @(negedge sys_clk);
    chk({15'h0, int_n_oe}, 16'h0000);
    gpio_in = 16'hA45B;
    repeat (10) @(negedge sys_clk);
    bus.start();
    bus.wr_byte({ADDR, 1'b0}, ack);
    bus.wr_byte(8'h01, ack);
    bus.start();
    bus.wr_byte({ADDR, 1'b1}, ack);
    bus.rd_byte(1'b1, q[7:0]);
    bus.stop();
    chk({8'h00, q[7:0]}, 16'h00A4);
    chk({15'h0, int_n_oe}, 16'h0000);
    $display("done irq");
  endtask
  task automatic t_rst();
    rst_n = 1'b0;
    strap = 2'b10;
    repeat (2) @(negedge sys_clk);
    chk(gpio_oe, 16'h0000);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    wreg({`GEX_ADDR_HI, 2'b10}, 8'h02, 16'h1234);
    chk({15'h0, ack}, 16'h0001);
    chk(gpio_out, 16'h1234);
    wreg(ADDR, 8'h02, 16'h0000);
    chk({15'h0, ack}, 16'h0000);
    chk(gpio_out, 16'h1234);
    rst_n = 1'b0;
    strap = 2'b01;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(gpio_out, 16'hFFFF);
    rreg(8'h06);
    chk(q, 16'hFFFF);
    $display("done midrun reset");
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    t_reset();
    t_input();
    t_output();
    t_irq();
    t_rst();
    complete_run();
  end
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule
